// File: hw/esr_top.sv
/*
  exception source routing: reset and nmi source gathering with sticky
  flags, a tick down-counter on the oscillator clock over 32, and routing
  of interrupt lines straight or through standby wake logic to the core.
  assumes pins and oscillator arrive asynchronous; peripherals are on mclk.
*/
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE_01 - reset pin low to high raises reset
// RULE_02 - record each reset source in flags
// RULE_03 - system reset request bit causes reset
// RULE_04 - deliver watchdog and lvd nmi, record source
// RULE_05 - enabled tick loads reload then decrements
// RULE_06 - tick at zero raises exception, sets flag
// RULE_07 - tick reference is oscillator over 32
// RULE_08 - highest priority pending request served first
// RULE_09 - non-wake peripheral requests go straight through
// RULE_10 - wake requests pass configured wake logic
// RULE_11 - non-wake pins bypass wake logic
// RULE_12 - set-pending bit acts like hardware request
// RULE_13 - request lines level sensitive, active high
// RULE_14 - disabled pin input reads as high
// RULE_15 - software drives pin low before enabling
// RULE_16 - numbers 0 to 5 are wake-capable pins
// RULE_17 - pins 0-3 in control a, 4-5 in b
// RULE_18 - 6 to 12 serial, reserved, i2c, no wake
// RULE_19 - flags sticky until cleared, reserved lines low
module esr_top
(
  input  wire logic        mclk,           // system clock
  input  wire logic        rst_n,          // synchronous reset
  input  wire logic        clk_en,         // freezes all state when low
  input  wire logic [3:0]  addr,           // register word index
  input  wire logic [31:0] wdata,          // write data
  input  wire logic        wr,             // write strobe
  input  wire logic        rd,             // read strobe
  output logic      [31:0] rdata,          // read data, cycle after rd
  input  wire logic        reset_pin,      // external reset pin level
  input  wire logic        por_req,        // power-on reset request
  input  wire logic        wdt_rst_req,    // watchdog reset request
  input  wire logic        lvd_rst_req,    // low-voltage reset request
  input  wire logic        wdt_nmi_req,    // watchdog nmi request
  input  wire logic        lvd_nmi_req,    // low-voltage nmi request
  input  wire logic        osc_clk,        // selected oscillator clock
  input  wire logic [5:0]  ext_irq_pin,    // external interrupt pins
  input  wire logic        serial0_receive_irq,   // peripheral request
  input  wire logic        serial0_transmit_irq,  // peripheral request
  input  wire logic        serial1_receive_irq,   // peripheral request
  input  wire logic        serial1_transmit_irq,  // peripheral request
  input  wire logic        i2c_channel_zero_irq,  // peripheral request
  input  wire logic        standby,        // core sits in standby
  input  wire logic [12:0] irq_clear,      // core clears forced pending
  output logic             sys_reset,      // reset exception pulse
  output logic             nmi,            // nmi exception pulse
  output logic             tick_exc,       // tick exception pulse
  output logic      [12:0] irq_line,       // request lines to core
  output logic             irq_valid,      // some line is active
  output logic      [3:0]  irq_top,        // lowest-numbered active line
  output logic             wake_up         // standby release
);

  logic [1:0]  pin_rst_s;
  logic        pin_rst_d;
  logic [5:0]  ext_s1;
  logic [5:0]  ext_s2;
  logic [5:0]  ext_d;
  logic [2:0]  osc_s;
  logic [4:0]  div_cnt;
  logic        ref_tick;
  logic [4:0]  reset_source_flags;
  logic [1:0]  nmi_source_flags;
  logic [12:0] set_pend;
  logic [31:0] wake_mode_ctrl_a;
  logic [31:0] wake_mode_ctrl_b;
  logic [5:0]  wake_sel;
  logic [5:0]  port_input_enable_reg;
  logic [1:0]  tick_ctrl;
  logic        tick_flag;
  logic [23:0] tick_load;
  logic [23:0] tick_val;
  logic        tick_run;
  logic [5:0]  ext_lvl;
  logic [5:0]  ext_prev;
  logic [5:0]  wake_hit;
  logic [12:0] raw_irq;
  logic [12:0] next_irq;
  logic        pin_rise;
  logic        sysreq_wr;
  logic        tick_zero;
  logic [31:0] next_rdata;
  logic [3:0]  next_top;

  // pin synchronisers
  always_ff @(posedge mclk)
  begin
    if (clk_en)
    begin
      pin_rst_s <= {pin_rst_s[0], reset_pin};
      ext_s1    <= ext_irq_pin;
      ext_s2    <= ext_s1;
      osc_s     <= {osc_s[1:0], osc_clk};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_rst_d <= 1'b0;
      ext_d     <= 6'h00;
      ext_prev  <= 6'h00;
    end
    else if (clk_en)
    begin
      pin_rst_d <= pin_rst_s[1];
      ext_d     <= ext_s2;
      ext_prev  <= ext_lvl;
    end
  end

  assign pin_rise  = pin_rst_s[1] & ~pin_rst_d;                                 // [RULE_01]
  assign sysreq_wr = wr && (addr == esr_pkg::OFS_RST_CTRL) && wdata[esr_pkg::SYSREQ_BIT]; // [RULE_03]
  // reset and nmi exception pulses
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sys_reset <= 1'b0;
      nmi       <= 1'b0;
    end
    else if (clk_en)
    begin
      sys_reset <= pin_rise | por_req | wdt_rst_req | lvd_rst_req | sysreq_wr; // [RULE_01] [RULE_03]
      nmi       <= wdt_nmi_req | lvd_nmi_req;                                  // [RULE_04]
    end
  end
  // sticky source flags, set wins over write-one clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reset_source_flags <= 5'h00;
      nmi_source_flags   <= 2'h0;
    end
    else if (clk_en)
    begin
      reset_source_flags <= (reset_source_flags
                             & ~((wr && addr == esr_pkg::OFS_RST_FLAGS) ? wdata[4:0] : 5'h00))
                            | {lvd_rst_req, sysreq_wr, wdt_rst_req, por_req, pin_rise}; // [RULE_02] [RULE_19]
      nmi_source_flags   <= (nmi_source_flags
                             & ~((wr && addr == esr_pkg::OFS_NMI_FLAGS) ? wdata[1:0] : 2'h0))
                            | {lvd_nmi_req, wdt_nmi_req};                       // [RULE_04] [RULE_19]
    end
  end
  // reference tick: oscillator rising edges divided by 32
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      div_cnt <= 5'h00;
    else if (clk_en && osc_s[1] && !osc_s[2])
      div_cnt <= div_cnt + 5'h01;                                              // [RULE_07]
  end
  assign ref_tick = clk_en && osc_s[1] && !osc_s[2] && (div_cnt == 5'(esr_pkg::TICK_DIV - 1)); // [RULE_07]
  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wake_mode_ctrl_a      <= 32'h00000000;
      wake_mode_ctrl_b      <= 32'h00000000;
      wake_sel              <= 6'h00;
      port_input_enable_reg <= 6'h00;
      tick_ctrl             <= 2'h0;
      tick_load             <= 24'h000000;
    end
    else if (clk_en && wr)
    begin
      unique case (addr)
        esr_pkg::OFS_WAKE_A:    wake_mode_ctrl_a      <= wdata;                // [RULE_17]
        esr_pkg::OFS_WAKE_B:    wake_mode_ctrl_b      <= {16'h0000, wdata[15:0]}; // [RULE_17]
        esr_pkg::OFS_WAKE_SEL:  wake_sel              <= wdata[5:0];
        esr_pkg::OFS_PORT_IE:   port_input_enable_reg <= wdata[5:0];
        esr_pkg::OFS_TICK_CTRL: tick_ctrl             <= wdata[1:0];
        esr_pkg::OFS_TICK_LOAD: tick_load             <= wdata[23:0];
        default:                ;
      endcase
    end
  end
  // tick counter
  assign tick_zero = tick_run && ref_tick && (tick_val == 24'h000001);
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tick_val  <= 24'h000000;
      tick_run  <= 1'b0;
      tick_flag <= 1'b0;
      tick_exc  <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_run <= tick_ctrl[esr_pkg::TICK_EN];
      if (!tick_ctrl[esr_pkg::TICK_EN])
        tick_val <= tick_val;
      else if (!tick_run || (ref_tick && tick_val == 24'h000000))
        tick_val <= tick_load;                                                 // [RULE_05]
      else if (ref_tick)
        tick_val <= tick_val - 24'h000001;                                     // [RULE_05]
      if (tick_zero)
        tick_flag <= 1'b1;                                                     // [RULE_06]
      else if (rd && addr == esr_pkg::OFS_TICK_CTRL)
        tick_flag <= 1'b0;
      tick_exc <= tick_zero && tick_ctrl[esr_pkg::TICK_INTEN];                 // [RULE_06]
    end
  end
  // pin level with input enable, disabled pin reads high
  assign ext_lvl = ext_d | ~port_input_enable_reg;                             // [RULE_14]
  // wake detection per pin
  generate
    for (genvar i = 0; i < 6; i++)
    begin : g_wake
      logic [2:0] mode;
      if (i < 4)
        assign mode = wake_mode_ctrl_a[i*esr_pkg::WAKE_FLD_SP +: esr_pkg::WAKE_FLD_W]; // [RULE_17]
      else
        assign mode = wake_mode_ctrl_b[(i-4)*esr_pkg::WAKE_FLD_SP +: esr_pkg::WAKE_FLD_W]; // [RULE_17]
      always_comb
      begin
        unique case (mode)
          esr_pkg::ESR_WAKE_LOW:  wake_hit[i] = ~ext_lvl[i];                   // [RULE_16]
          esr_pkg::ESR_WAKE_HIGH: wake_hit[i] = ext_lvl[i];
          esr_pkg::ESR_WAKE_RISE: wake_hit[i] = ext_lvl[i] & ~ext_prev[i];
          esr_pkg::ESR_WAKE_FALL: wake_hit[i] = ~ext_lvl[i] & ext_prev[i];
          esr_pkg::ESR_WAKE_BOTH: wake_hit[i] = ext_lvl[i] ^ ext_prev[i];
          default:                wake_hit[i] = 1'b0;
        endcase
      end
    end
  endgenerate
  // routing: wake pins through wake logic, others direct
  assign raw_irq = {i2c_channel_zero_irq, 2'b00, serial1_transmit_irq, serial1_receive_irq,
                    serial0_transmit_irq, serial0_receive_irq,
                    (wake_sel & wake_hit) | (~wake_sel & ext_lvl)};            // [RULE_09] [RULE_10] [RULE_11] [RULE_18]
  assign next_irq = (raw_irq | set_pend) & ~esr_pkg::IRQ_RSVD_MASK;            // [RULE_12] [RULE_19]
  // forced pending, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      set_pend <= 13'h0000;
    else if (clk_en)
      set_pend <= (set_pend & ~irq_clear)
                  | ((wr && addr == esr_pkg::OFS_SET_PEND) ? wdata[12:0] : 13'h0000); // [RULE_12]
  end
  always_comb
  begin
    next_top = 4'h0;
    for (int k = 12; k >= 0; k--)
      if (next_irq[k])
        next_top = 4'(k);                                                      // [RULE_08]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      irq_line  <= 13'h0000;
      irq_valid <= 1'b0;
      irq_top   <= 4'h0;
      wake_up   <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_line  <= next_irq;                                                   // [RULE_13]
      irq_valid <= |next_irq;
      irq_top   <= next_top;                                                   // [RULE_08]
      wake_up   <= standby && |(wake_sel & wake_hit);                          // [RULE_10]
    end
  end
  // register read port
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (addr)
      esr_pkg::OFS_RST_FLAGS:  next_rdata = {27'h0, reset_source_flags};
      esr_pkg::OFS_NMI_FLAGS:  next_rdata = {30'h0, nmi_source_flags};
      esr_pkg::OFS_SET_PEND:   next_rdata = {19'h0, set_pend};
      esr_pkg::OFS_WAKE_A:     next_rdata = wake_mode_ctrl_a;
      esr_pkg::OFS_WAKE_B:     next_rdata = wake_mode_ctrl_b;
      esr_pkg::OFS_WAKE_SEL:   next_rdata = {26'h0, wake_sel};
      esr_pkg::OFS_PORT_IE:    next_rdata = {26'h0, port_input_enable_reg};
      esr_pkg::OFS_TICK_CTRL:  next_rdata = {15'h0, tick_flag, 14'h0, tick_ctrl};
      esr_pkg::OFS_TICK_LOAD:  next_rdata = {8'h0, tick_load};
      esr_pkg::OFS_TICK_VAL:   next_rdata = {8'h0, tick_val};
      esr_pkg::OFS_PENDING:    next_rdata = {19'h0, irq_line};
      default:                 next_rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else if (clk_en)
      rdata <= rd ? next_rdata : 32'h00000000;
  end
  // assertions
  property p_pin_reset;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && pin_rise) |=> sys_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin rise gave no reset"); // [RULE_01]
  property p_rst_flag_sticky;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && wdt_rst_req) |=> reset_source_flags[esr_pkg::RST_WDT];
  endproperty
  a_rst_flag_sticky: assert property (p_rst_flag_sticky) else $error("wdt reset flag not set"); // [RULE_02]
  property p_sysreq;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && sysreq_wr) |=> (sys_reset && reset_source_flags[esr_pkg::RST_SYSREQ]);
  endproperty
  a_sysreq: assert property (p_sysreq) else $error("reset request write lost"); // [RULE_03]
  property p_nmi;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && lvd_nmi_req) |=> (nmi && nmi_source_flags[esr_pkg::NMI_LVD]);
  endproperty
  a_nmi: assert property (p_nmi) else $error("lvd nmi not delivered"); // [RULE_04]
  sequence s_tick_at_one;
    tick_zero && tick_ctrl[esr_pkg::TICK_INTEN] && clk_en;
  endsequence
  property p_tick_exc;
    @(posedge mclk) disable iff (!rst_n)
    s_tick_at_one |=> (tick_exc && tick_flag);
  endproperty
  a_tick_exc: assert property (p_tick_exc) else $error("tick zero not signalled"); // [RULE_06]
  property p_tick_step;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && tick_run && tick_ctrl[esr_pkg::TICK_EN] && ref_tick && tick_val != 24'h000000)
      |=> (tick_val == $past(tick_val) - 24'h000001);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick did not decrement"); // [RULE_05]
  property p_disabled_pin_high;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && !port_input_enable_reg[0] && !wake_sel[0]) |=> irq_line[0];
  endproperty
  a_disabled_pin_high: assert property (p_disabled_pin_high) else $error("disabled pin not high"); // [RULE_14]
  property p_reserved_low;
    @(posedge mclk) disable iff (!rst_n)
    (irq_line[11:10] == 2'b00);
  endproperty
  a_reserved_low: assert property (p_reserved_low) else $error("reserved line active"); // [RULE_19]
  property p_direct_serial;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && serial0_receive_irq) |=> irq_line[6];
  endproperty
  a_direct_serial: assert property (p_direct_serial) else $error("serial request not routed"); // [RULE_09]
  property p_set_pend;
    @(posedge mclk) disable iff (!rst_n)
    (clk_en && wr && addr == esr_pkg::OFS_SET_PEND && wdata[7]) |=> ##1 irq_line[7];
  endproperty
  a_set_pend: assert property (p_set_pend) else $error("forced pending missing"); // [RULE_12]
endmodule

`default_nettype wire

// File: hw/esr_pkg.sv
/*
  constants for the exception source routing block: register offsets,
  field positions, interrupt numbering, tick divider.
  assumes a single 50 MHz system clock domain.
*/
package esr_pkg;
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned NUM_IRQ       = 13;
  localparam int unsigned NUM_EXT       = 6;
  localparam int unsigned TICK_DIV      = 32;
  localparam int unsigned TICK_DIV_W    = 5;
  localparam int unsigned TICK_W        = 24;

  // register offsets (word index, byte address = 4 * index)
  localparam logic [3:0] OFS_RST_FLAGS  = 4'h0;
  localparam logic [3:0] OFS_NMI_FLAGS  = 4'h1;
  localparam logic [3:0] OFS_RST_CTRL   = 4'h2;
  localparam logic [3:0] OFS_SET_PEND   = 4'h3;
  localparam logic [3:0] OFS_WAKE_A     = 4'h4;
  localparam logic [3:0] OFS_WAKE_B     = 4'h5;
  localparam logic [3:0] OFS_WAKE_SEL   = 4'h6;
  localparam logic [3:0] OFS_PORT_IE    = 4'h7;
  localparam logic [3:0] OFS_TICK_CTRL  = 4'h8;
  localparam logic [3:0] OFS_TICK_LOAD  = 4'h9;
  localparam logic [3:0] OFS_TICK_VAL   = 4'ha;
  localparam logic [3:0] OFS_PENDING    = 4'hb;

  // reset source flag bits
  localparam int unsigned RST_PIN       = 0;
  localparam int unsigned RST_POR       = 1;
  localparam int unsigned RST_WDT       = 2;
  localparam int unsigned RST_SYSREQ    = 3;
  localparam int unsigned RST_LVD       = 4;
  localparam int unsigned RST_N_SRC     = 5;
  // nmi source flag bits
  localparam int unsigned NMI_WDT       = 0;
  localparam int unsigned NMI_LVD       = 1;
  // system reset request bit in the control word
  localparam int unsigned SYSREQ_BIT    = 2;
  // tick control fields
  localparam int unsigned TICK_EN       = 0;
  localparam int unsigned TICK_INTEN    = 1;
  localparam int unsigned TICK_FLAG     = 16;
  // reserved interrupt lines
  localparam logic [12:0] IRQ_RSVD_MASK = 13'h0c00;
  // wake field width per pin: 3 bits on an 8-bit stride, 4 pins in control a, 2 in b
  localparam int unsigned WAKE_FLD_W    = 3;
  localparam int unsigned WAKE_FLD_SP   = 8;

  typedef enum logic [2:0]
  {
    ESR_WAKE_LOW   = 3'b000,
    ESR_WAKE_HIGH  = 3'b001,
    ESR_WAKE_RISE  = 3'b010,
    ESR_WAKE_FALL  = 3'b011,
    ESR_WAKE_BOTH  = 3'b100
  } esr_wake_mode_t;
endpackage

// File: sim/esr_partner.sv
/*
  far-side model: peripheral request sources, free-running oscillator
  and the core clearing the forced-pending line it services.
  assumes the bench commands request levels and service pulses on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module esr_partner
(
  input  wire logic        mclk,      // system clock
  input  wire logic [4:0]  req_cmd,   // wanted levels: rx0,tx0,rx1,tx1,i2c
  input  wire logic        ack_cmd,   // core services the chosen line
  input  wire logic [3:0]  irq_top,   // line chosen by the block
  output logic             osc_clk,   // oscillator, 60 ns period
  output logic      [4:0]  req,       // peripheral request levels
  output logic      [12:0] irq_clear  // clear pulse to the block
);
  // oscillator runs free, edges kept clear of mclk edges
  initial
  begin
    osc_clk = 1'b0;
    #5;
    forever #30 osc_clk = ~osc_clk;
  end

  always @(posedge mclk)
  begin
    req       <= req_cmd;
    irq_clear <= ack_cmd ? 13'h0001 << irq_top : 13'h0000;
  end
endmodule
`default_nettype wire

// File: sim/tb_esr_top.sv
/*
  self-checking bench for the exception source routing block:
  register tasks, reset and nmi sources, tick, routing, forced pending.
  assumes esr_pkg, esr_top and esr_partner are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_esr_top;
  logic        mclk, rst_n, wr, rd, standby, ack_cmd, osc_clk;
  logic        reset_pin, por_req, wdt_rst_req, lvd_rst_req, wdt_nmi_req, lvd_nmi_req;
  logic        sys_reset, nmi, tick_exc, irq_valid, wake_up;
  logic [3:0]  addr, irq_top;
  logic [31:0] wdata, rdata, v;
  logic [5:0]  ext_irq_pin;
  logic [4:0]  req_cmd, req;
  logic [12:0] irq_clear, irq_line;
  int          err_count, n_checks, cyc, t0, p, b;

  esr_top esr_top_i
  (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .reset_pin(reset_pin), .por_req(por_req), .wdt_rst_req(wdt_rst_req),
    .lvd_rst_req(lvd_rst_req), .wdt_nmi_req(wdt_nmi_req), .lvd_nmi_req(lvd_nmi_req),
    .osc_clk(osc_clk), .ext_irq_pin(ext_irq_pin), .serial0_receive_irq(req[0]),
    .serial0_transmit_irq(req[1]), .serial1_receive_irq(req[2]), .serial1_transmit_irq(req[3]),
    .i2c_channel_zero_irq(req[4]), .standby(standby), .irq_clear(irq_clear),
    .sys_reset(sys_reset), .nmi(nmi), .tick_exc(tick_exc), .irq_line(irq_line),
    .irq_valid(irq_valid), .irq_top(irq_top), .wake_up(wake_up)
  );

  esr_partner esr_partner_i
  (
    .mclk(mclk), .req_cmd(req_cmd), .ack_cmd(ack_cmd), .irq_top(irq_top),
    .osc_clk(osc_clk), .req(req), .irq_clear(irq_clear)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // 0 reset, 1 nmi, 2 tick, 3 wake; looks 1 ns after each edge
  task automatic wait_hi(input int w, input int lim, output logic hit);
    logic s;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      #1;
      s   = (w == 0) ? sys_reset : (w == 1) ? nmi : (w == 2) ? tick_exc : wake_up;
      hit = (s === 1'b1);
      if (!hit)
        @(posedge mclk);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk)
    cyc <= cyc + 1;

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    results();
  end

  initial
  begin : main
    logic h;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    standby = 1'b0;
    ack_cmd = 1'b0;
    reset_pin = 1'b0;
    por_req = 1'b0;
    wdt_rst_req = 1'b0;
    lvd_rst_req = 1'b0;
    wdt_nmi_req = 1'b0;
    lvd_nmi_req = 1'b0;
    ext_irq_pin = 6'h00;
    req_cmd = 5'h00;
    err_count = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // pins held low, then inputs enabled
    wreg(esr_pkg::OFS_WAKE_SEL, 32'h0);
    wreg(esr_pkg::OFS_PORT_IE, 32'h3f);
    repeat (8) @(posedge mclk);
    #1 chk(irq_line, 13'h0000);
    @(posedge mclk);
    ext_irq_pin <= 6'h04;
    repeat (8) @(posedge mclk);
    #1 chk({irq_top, irq_line}, {4'h2, 13'h0004});
    @(posedge mclk);
    ext_irq_pin <= 6'h00;
    wreg(esr_pkg::OFS_PORT_IE, 32'h0);
    repeat (8) @(posedge mclk);
    #1 chk(irq_line, 13'h003f);
    wreg(esr_pkg::OFS_PORT_IE, 32'h3f);
    repeat (8) @(posedge mclk);
    // reset sources: pin, por, watchdog, low voltage
    for (int k = 0; k < 4; k++)
    begin
      b = (k == 0) ? esr_pkg::RST_PIN : (k == 1) ? esr_pkg::RST_POR :
          (k == 2) ? esr_pkg::RST_WDT : esr_pkg::RST_LVD;
      @(posedge mclk);
      case (k)
        0: reset_pin <= 1'b1;
        1: por_req <= 1'b1;
        2: wdt_rst_req <= 1'b1;
        default: lvd_rst_req <= 1'b1;
      endcase
      @(posedge mclk);
      {por_req, wdt_rst_req, lvd_rst_req} <= 3'h0;
      wait_hi(0, 8, h);
      chk(h, 1'b1);
      repeat (3) @(posedge mclk);
      rreg(esr_pkg::OFS_RST_FLAGS, v);
      chk(v, 32'h1 << b);
      wreg(esr_pkg::OFS_RST_FLAGS, 32'h1 << b);
      rreg(esr_pkg::OFS_RST_FLAGS, v);
      chk(v, 32'h0);
    end
    wreg(esr_pkg::OFS_RST_CTRL, 32'h1 << esr_pkg::SYSREQ_BIT);
    wait_hi(0, 8, h);
    chk(h, 1'b1);
    rreg(esr_pkg::OFS_RST_FLAGS, v);
    chk(v, 32'h1 << esr_pkg::RST_SYSREQ);
    wreg(esr_pkg::OFS_RST_FLAGS, 32'h1f);
    // nmi sources: watchdog, low voltage
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      if (k == 0)
        wdt_nmi_req <= 1'b1;
      else
        lvd_nmi_req <= 1'b1;
      @(posedge mclk);
      {wdt_nmi_req, lvd_nmi_req} <= 2'h0;
      wait_hi(1, 4, h);
      chk(h, 1'b1);
      rreg(esr_pkg::OFS_NMI_FLAGS, v);
      chk(v, 32'h1 << (k == 0 ? esr_pkg::NMI_WDT : esr_pkg::NMI_LVD));
      wreg(esr_pkg::OFS_NMI_FLAGS, 32'h3);
    end
    // tick: reload 3, one tick is 32 osc periods of 3 mclk
    wreg(esr_pkg::OFS_TICK_LOAD, 32'h3);
    wreg(esr_pkg::OFS_TICK_CTRL, 32'h3);
    repeat (2) @(posedge mclk);
    rreg(esr_pkg::OFS_TICK_VAL, v);
    chk(v === 32'h3 || v === 32'h2, 1'b1);
    wait_hi(2, 500, h);
    chk(h, 1'b1);
    t0 = cyc;
    @(posedge mclk);
    wait_hi(2, 500, h);
    chk(cyc - t0 >= 383 && cyc - t0 <= 385, 1'b1);
    rreg(esr_pkg::OFS_TICK_CTRL, v);
    chk(v[16], 1'b1);
    rreg(esr_pkg::OFS_TICK_CTRL, v);
    chk(v[16], 1'b0);
    wreg(esr_pkg::OFS_TICK_CTRL, 32'h0);
    // peripheral lines go straight through
    for (int k = 0; k < 5; k++)
    begin
      p = (k == 4) ? 12 : k + 6;
      @(posedge mclk);
      req_cmd <= 5'h01 << k;
      repeat (4) @(posedge mclk);
      #1 chk({irq_valid, irq_top, irq_line}, {1'b1, p[3:0], 13'h1 << p});
      @(posedge mclk);
      req_cmd <= 5'h00;
    end
    repeat (4) @(posedge mclk);
    // forced pending, reserved bit 10 must stay low
    wreg(esr_pkg::OFS_SET_PEND, 32'h1480);
    repeat (3) @(posedge mclk);
    #1 chk({irq_top, irq_line}, {4'h7, 13'h1080});
    rreg(esr_pkg::OFS_PENDING, v);
    chk(v, 32'h1080);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      ack_cmd <= 1'b1;
      @(posedge mclk);
      ack_cmd <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk({irq_valid, irq_top, irq_line}, k ? 18'h0 : {1'b1, 4'hc, 13'h1000});
    end
    // wake modes low, high, rise, fall, both on pins 0 to 4
    for (int m = 0; m < 5; m++)
    begin
      @(posedge mclk);
      ext_irq_pin <= ((m == 0 || m == 3) ? 6'h01 : 6'h00) << m;
      wreg(esr_pkg::OFS_WAKE_SEL, 32'h1 << m);
      wreg(m < 4 ? esr_pkg::OFS_WAKE_A : esr_pkg::OFS_WAKE_B, m << (8 * (m % 4)));
      repeat (8) @(posedge mclk);
      standby <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(wake_up, 1'b0);
      @(posedge mclk);
      ext_irq_pin <= ext_irq_pin ^ (6'h01 << m);
      wait_hi(3, 10, h);
      chk(h, 1'b1);
      @(posedge mclk);
      standby     <= 1'b0;
      ext_irq_pin <= 6'h00;
    end
    // unmapped places and unused upper half
    wreg(4'hd, 32'hffffffff);
    rreg(4'hd, v);
    chk(v, 32'h0);
    rreg(4'hc, v);
    chk(v, 32'h0);
    wreg(esr_pkg::OFS_WAKE_B, 32'hffffffff);
    rreg(esr_pkg::OFS_WAKE_B, v);
    chk(v[31:16], 16'h0);
    results();
  end
endmodule
`default_nettype wire
